// file: pos_host_pkg.sv
// Word map, limits, codes and types for the position-table host controller
package pos_host_pkg;
  // Clock and zone watchdog timing
  localparam int CLK_FREQ_HZ = 20000000;
  localparam int WD_ZONE_TIME_MS = 1000;
  localparam int WD_ZONE_CYCLES = WD_ZONE_TIME_MS * (CLK_FREQ_HZ / 1000);
  // Data word addresses in the device transfer area
  localparam logic [9:0] WORD_DIST_OUTER = 10'h032;
  localparam logic [9:0] WORD_COUNT = 10'h03a;
  localparam logic [9:0] WORD_ENTRY_BASE = 10'h03c;
  localparam logic [9:0] WORD_ENTRY_END = 10'h335;
  localparam logic [9:0] ENTRY_WORDS = 10'h003;
  // Position numbers
  localparam logic [7:0] MAX_POS = 8'hfe;
  localparam logic [7:0] NUM_SKIP = 8'hff;
  // Value limits
  localparam logic signed [31:0] LIN_LIMIT = 32'sh0098967f;
  localparam logic signed [31:0] DIST_MAX = 32'sh000f423f;
  localparam logic signed [31:0] DIST_MIN = 32'sh00000001;
  localparam logic signed [31:0] BIN_LIMIT = 32'sh00800000;
  // Value encoding
  localparam logic [4:0] BCD_STEPS = 5'h18;
  localparam logic [3:0] BCD_SIGN_NEG = 4'hf;
  // Error codes
  localparam logic [2:0] ERR_NONE = 3'h0;
  localparam logic [2:0] ERR_DIST = 3'h1;
  localparam logic [2:0] ERR_COUNT = 3'h2;
  localparam logic [2:0] ERR_NUM = 3'h3;
  localparam logic [2:0] ERR_DUP = 3'h4;
  localparam logic [2:0] ERR_VALUE = 3'h5;
  localparam logic [2:0] ERR_INDEX = 3'h6;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_CHECK = 4'h1, S_CONV = 4'h2, S_WHI = 4'h3, S_WLO = 4'h4,
    S_WCNT = 4'h5, S_WAIT_ENT = 4'h6, S_WNUM = 4'h7, S_GO = 4'h8
  } state_type;

  typedef enum logic [1:0] {PH_DIST = 2'h0, PH_ENTRY = 2'h1, PH_UPD = 2'h2} phase_type;

  typedef struct packed {
    logic [7:0] num;
    logic signed [31:0] value;
  } entry_type;

  typedef struct packed {
    logic signed [31:0] outer;
    logic signed [31:0] middle;
    logic signed [31:0] inner;
  } dist_set_type;

  // First data word of a position entry, zero-based entry index
  function automatic logic [9:0] entry_word(input logic [7:0] idx);
    return WORD_ENTRY_BASE + 10'(idx) * ENTRY_WORDS;
  endfunction
endpackage

// file: pos_value_encoder.sv
// Encodes a signed value into two data words, binary or signed BCD
`timescale 1ns/1ps
module pos_value_encoder (
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic start, // Pulse: latch value and encode
  input wire logic bcd_mode, // 1: BCD words, 0: binary words
  input wire logic signed [31:0] value, // Value to encode
  output logic done, // Pulse: words valid
  output logic [15:0] word_hi, // First data word
  output logic [15:0] word_lo // Second data word
);
  import pos_host_pkg::*;

  logic [27:0] bcd_reg, bcd_next;
  logic [23:0] mag_reg, mag_next;
  logic [4:0] cnt_reg, cnt_next;
  logic neg_reg, neg_next;
  logic busy_reg, busy_next;
  logic done_reg, done_next;
  logic mode_reg, mode_next;
  logic [31:0] out_reg, out_next;

  // Add three to every digit above four before each shift
  function automatic logic [27:0] bcd_adjust(input logic [27:0] d);
    logic [27:0] r;
    r = d;
    for (int i = 0; i < 7; i++) begin
      if (r[i*4 +: 4] > 4'h4) r[i*4 +: 4] = r[i*4 +: 4] + 4'h3;
    end
    return r;
  endfunction

  // Binary answers in one cycle; BCD walks 24 shift steps
  // sign-extended binary or signed BCD
  always_comb begin
    logic [27:0] adj;
    adj = bcd_adjust(bcd_reg);
    bcd_next = bcd_reg;
    mag_next = mag_reg;
    cnt_next = cnt_reg;
    neg_next = neg_reg;
    busy_next = busy_reg;
    mode_next = mode_reg;
    out_next = out_reg;
    done_next = 1'b0;
    if (start) begin
      mode_next = bcd_mode;
      if (bcd_mode) begin
        neg_next = value[31];
        mag_next = value[31] ? 24'(-value) : value[23:0];
        bcd_next = '0;
        cnt_next = BCD_STEPS;
        busy_next = 1'b1;
      end else begin
        out_next = {{8{value[23]}}, value[23:0]};
        done_next = 1'b1;
      end
    end else if (busy_reg) begin
      {bcd_next, mag_next} = {adj[26:0], mag_reg, 1'b0};
      cnt_next = cnt_reg - 5'h01;
      if (cnt_reg == 5'h01) begin
        busy_next = 1'b0;
        done_next = 1'b1;
        out_next = {neg_reg ? BCD_SIGN_NEG : 4'h0, adj[26:0], mag_reg[23]};
      end
    end
  end

  // Register stage
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bcd_reg <= '0;
      mag_reg <= '0;
      cnt_reg <= '0;
      neg_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      mode_reg <= 1'b0;
      out_reg <= '0;
    end else begin
      bcd_reg <= bcd_next;
      mag_reg <= mag_next;
      cnt_reg <= cnt_next;
      neg_reg <= neg_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
      mode_reg <= mode_next;
      out_reg <= out_next;
    end
  end

  assign done = done_reg;
  assign word_hi = out_reg[31:16];
  assign word_lo = out_reg[15:0];

  AST_BIN_LATENCY: assert property (@(posedge clk_sys) disable iff (!rst_n)
    start && !bcd_mode |=> done && (word_hi[15:8] == {8{word_hi[7]}}))
    else $error("binary encode not sign extended in one cycle");
  AST_BCD_LATENCY: assert property (@(posedge clk_sys) disable iff (!rst_n)
    start && bcd_mode |-> !done [*8] ##18 done)
    else $error("BCD encode latency wrong");
  AST_BCD_SIGN: assert property (@(posedge clk_sys) disable iff (!rst_n)
    done && mode_reg |-> word_hi[15:12] == (neg_reg ? BCD_SIGN_NEG : 4'h0))
    else $error("BCD sign nibble wrong");
endmodule // pos_value_encoder

// file: pos_table_host.sv
// Host controller that loads and updates a device position table and times approach zones
`timescale 1ns/1ps
// Function
// - Values lie within plus/minus 9,999,999 linear, or 0 to rotary final minus one.
// - Numbers are 1 to 254, each used once; duplicates are errors.
// - Host writes position count 0 to 254 in word 58 low byte, high zero.
// - Entries take three words from word 60; number first, then value.
// - Values are binary sign-extended from 24 bits or seven BCD digits plus sign.
// - Later value changes address entries by list index, not number.
// - Outer distance exceeds middle, middle exceeds inner.
// - Outer, middle, inner distances go in words 50-51, 52-53, 54-55.
// - Distances 1 to 999,999; rotary also at most half the final value.
// - Host should time each approach zone and overtravel with watchdogs.
module pos_table_host #(
  parameter int unsigned WD_CYCLES = pos_host_pkg::WD_ZONE_CYCLES // Zone watchdog limit
) (
  input wire logic clk_sys, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic cfg_start, // Pulse: start a configuration transfer
  input wire logic [7:0] cfg_count, // Number of entries to transfer
  input wire logic cfg_bcd, // 1: send values in BCD
  input wire logic cfg_rotary, // 1: rotary axis
  input wire logic signed [31:0] cfg_rot_final, // Rotary final value
  input pos_host_pkg::dist_set_type cfg_dist, // Outer, middle, inner distances
  input wire logic ent_valid, // Entry offered
  input pos_host_pkg::entry_type ent, // Entry number and value
  input wire logic upd_valid, // Pulse: change a stored value
  input wire logic [7:0] upd_index, // One-based entry index to change
  input wire logic signed [31:0] upd_value, // New value
  input wire logic sel_pulse, // Pulse: a position was selected
  input wire logic wd_clear, // Pulse: stop and clear the watchdog
  input wire logic dev_err_pin, // Device error pin, asynchronous
  input wire logic [2:0] dev_flags_pin, // Outer, middle, inner range flags
  output logic [9:0] dw_addr, // Data word address to device
  output logic [15:0] dw_data, // Data word to device
  output logic dw_wr, // Pulse: write data word
  output logic cfg_go, // Pulse: transfer complete
  output logic ent_ready, // Entry accepted when valid
  output logic host_busy, // Sequence in progress
  output logic [2:0] err_code, // Last refusal, 0 when none
  output logic dev_error, // Synchronised device error
  output logic wd_timeout // Zone time exceeded, sticky
);
  import pos_host_pkg::*;

  localparam logic [31:0] WD_LAST = 32'(WD_CYCLES - 1);
  if (WD_CYCLES < 2) begin : g_bad_wd
    $error("WD_CYCLES must be at least 2");
  end

  state_type state_reg, state_next;
  phase_type phase_reg, phase_next;
  logic [7:0] idx_reg, idx_next, count_reg, count_next, num_reg, num_next;
  logic bcd_reg, bcd_next, rotary_reg, rotary_next, skip_reg, skip_next;
  logic signed [31:0] rot_final_reg, rot_final_next, enc_val_reg, enc_val_next;
  dist_set_type dist_reg, dist_next;
  logic [255:0] used_reg, used_next;
  logic configured_reg, configured_next, enc_start_reg, enc_start_next;
  logic [9:0] addr_reg, addr_next, dw_addr_reg, dw_addr_next;
  logic [15:0] dw_data_reg, dw_data_next;
  logic dw_wr_reg, dw_wr_next, go_reg, go_next, ready_reg, ready_next, busy_reg, busy_next;
  logic [2:0] err_reg, err_next;
  logic enc_done;
  logic [15:0] enc_hi, enc_lo;

  // Value check against the axis kind and the chosen encoding
  function automatic logic value_ok(input logic signed [31:0] v);
    logic rng;
    rng = rotary_reg ? (v >= 0 && v < rot_final_reg) : (v >= -LIN_LIMIT && v <= LIN_LIMIT);
    return rng && (bcd_reg || (v >= -BIN_LIMIT && v < BIN_LIMIT));
  endfunction

  function automatic logic dist_ok(input logic signed [31:0] d);
    return d >= DIST_MIN && d <= DIST_MAX && (!rotary_reg || (d <<< 1) <= rot_final_reg);
  endfunction

  function automatic logic signed [31:0] dist_pick(input logic [7:0] k);
    return (k == 8'h00) ? dist_reg.outer : ((k == 8'h01) ? dist_reg.middle : dist_reg.inner);
  endfunction

  // Words are converted one at a time; a shared encoder saves area
  pos_value_encoder u_enc (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(enc_start_reg),
    .bcd_mode(bcd_reg),
    .value(enc_val_reg),
    .done(enc_done),
    .word_hi(enc_hi),
    .word_lo(enc_lo)
  );

  // Transfer sequencer
  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    idx_next = idx_reg;
    count_next = count_reg;
    num_next = num_reg;
    bcd_next = bcd_reg;
    rotary_next = rotary_reg;
    skip_next = skip_reg;
    rot_final_next = rot_final_reg;
    enc_val_next = enc_val_reg;
    dist_next = dist_reg;
    used_next = used_reg;
    configured_next = configured_reg;
    enc_start_next = 1'b0;
    addr_next = addr_reg;
    dw_addr_next = dw_addr_reg;
    dw_data_next = dw_data_reg;
    dw_wr_next = 1'b0;
    go_next = 1'b0;
    err_next = err_reg;
    unique case (state_reg)
      S_IDLE: begin
        if (cfg_start) begin
          count_next = cfg_count;
          bcd_next = cfg_bcd;
          rotary_next = cfg_rotary;
          rot_final_next = cfg_rot_final;
          dist_next = cfg_dist;
          used_next = '0;
          configured_next = 1'b0;
          err_next = ERR_NONE;
          idx_next = 8'h00;
          phase_next = PH_DIST;
          state_next = S_CHECK;
        end else if (upd_valid && configured_reg) begin
          if (upd_index == 8'h00 || upd_index > count_reg) begin
            err_next = ERR_INDEX;
          end else if (!value_ok(upd_value)) begin
            err_next = ERR_VALUE;
          end else begin
            err_next = ERR_NONE;
            idx_next = upd_index;
            addr_next = entry_word(upd_index - 8'h01) + 10'h001;
            enc_val_next = upd_value;
            enc_start_next = 1'b1;
            phase_next = PH_UPD;
            state_next = S_CONV;
          end
        end
      end
      S_CHECK: begin
        // nesting and limits checked before anything is sent
        if (count_reg > MAX_POS) begin
          err_next = ERR_COUNT;
          state_next = S_IDLE;
        end else if (!(dist_reg.outer > dist_reg.middle && dist_reg.middle > dist_reg.inner)
            || !dist_ok(dist_reg.outer) || !dist_ok(dist_reg.middle)
            || !dist_ok(dist_reg.inner)) begin
          err_next = ERR_DIST;
          state_next = S_IDLE;
        end else begin
          enc_val_next = dist_reg.outer;
          enc_start_next = 1'b1;
          addr_next = WORD_DIST_OUTER;
          state_next = S_CONV;
        end
      end
      S_CONV: begin
        if (enc_done) state_next = S_WHI;
      end
      S_WHI: begin
        dw_addr_next = addr_reg;
        dw_data_next = enc_hi;
        dw_wr_next = 1'b1;
        state_next = S_WLO;
      end
      S_WLO: begin
        dw_addr_next = addr_reg + 10'h001;
        dw_data_next = enc_lo;
        dw_wr_next = 1'b1;
        if (phase_reg == PH_DIST) begin
          if (idx_reg == 8'h02) begin
            state_next = S_WCNT;
          end else begin
            idx_next = idx_reg + 8'h01;
            enc_val_next = dist_pick(idx_reg + 8'h01);
            enc_start_next = 1'b1;
            addr_next = addr_reg + 10'h002;
            state_next = S_CONV;
          end
        end else if (phase_reg == PH_ENTRY) begin
          idx_next = idx_reg + 8'h01;
          state_next = (idx_reg + 8'h01 == count_reg) ? S_GO : S_WAIT_ENT;
        end else begin
          state_next = S_IDLE;
        end
      end
      S_WCNT: begin
        dw_addr_next = WORD_COUNT;
        dw_data_next = {8'h00, count_reg};
        dw_wr_next = 1'b1;
        idx_next = 8'h00;
        phase_next = PH_ENTRY;
        state_next = (count_reg == 8'h00) ? S_GO : S_WAIT_ENT;
      end
      S_WAIT_ENT: begin
        if (ent_valid && ready_reg) begin
          num_next = ent.num;
          // value words follow the number word
          addr_next = entry_word(idx_reg) + 10'h001;
          skip_next = (ent.num == NUM_SKIP);
          state_next = S_WNUM;
          if (ent.num == NUM_SKIP) begin
            state_next = S_WNUM;
          end else if (ent.num == 8'h00) begin
            err_next = ERR_NUM;
            state_next = S_IDLE;
          end else if (used_reg[ent.num]) begin
            err_next = ERR_DUP;
            state_next = S_IDLE;
          end else if (!value_ok(ent.value)) begin
            err_next = ERR_VALUE;
            state_next = S_IDLE;
          end else begin
            used_next[ent.num] = 1'b1;
            enc_val_next = ent.value;
            enc_start_next = 1'b1;
          end
        end
      end
      S_WNUM: begin
        dw_addr_next = entry_word(idx_reg);
        dw_data_next = {8'h00, num_reg};
        dw_wr_next = 1'b1;
        if (skip_reg) begin
          idx_next = idx_reg + 8'h01;
          state_next = (idx_reg + 8'h01 == count_reg) ? S_GO : S_WAIT_ENT;
        end else begin
          state_next = S_CONV;
        end
      end
      S_GO: begin
        go_next = 1'b1;
        configured_next = 1'b1;
        state_next = S_IDLE;
      end
    endcase
    ready_next = (state_next == S_WAIT_ENT);
    busy_next = (state_next != S_IDLE);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= S_IDLE;
      phase_reg <= PH_DIST;
      idx_reg <= '0;
      count_reg <= '0;
      num_reg <= '0;
      bcd_reg <= 1'b0;
      rotary_reg <= 1'b0;
      skip_reg <= 1'b0;
      rot_final_reg <= '0;
      enc_val_reg <= '0;
      dist_reg <= '0;
      used_reg <= '0;
      configured_reg <= 1'b0;
      enc_start_reg <= 1'b0;
      addr_reg <= '0;
      dw_addr_reg <= '0;
      dw_data_reg <= '0;
      dw_wr_reg <= 1'b0;
      go_reg <= 1'b0;
      ready_reg <= 1'b0;
      busy_reg <= 1'b0;
      err_reg <= ERR_NONE;
    end else begin
      state_reg <= state_next;
      phase_reg <= phase_next;
      idx_reg <= idx_next;
      count_reg <= count_next;
      num_reg <= num_next;
      bcd_reg <= bcd_next;
      rotary_reg <= rotary_next;
      skip_reg <= skip_next;
      rot_final_reg <= rot_final_next;
      enc_val_reg <= enc_val_next;
      dist_reg <= dist_next;
      used_reg <= used_next;
      configured_reg <= configured_next;
      enc_start_reg <= enc_start_next;
      addr_reg <= addr_next;
      dw_addr_reg <= dw_addr_next;
      dw_data_reg <= dw_data_next;
      dw_wr_reg <= dw_wr_next;
      go_reg <= go_next;
      ready_reg <= ready_next;
      busy_reg <= busy_next;
      err_reg <= err_next;
    end
  end

  // Pin synchronisers and zone watchdog
  logic dev_err_meta_reg, dev_err_reg;
  logic [2:0] flags_meta_reg, flags_sync_reg, zone_reg, zone_next;
  logic wd_arm_reg, wd_arm_next, wd_tmo_reg, wd_tmo_next;
  logic [31:0] wd_cnt_reg, wd_cnt_next;
  logic wd_fire;

  // zone timer restarts on every flag change, so each zone gets the full limit
  always_comb begin
    zone_next = flags_sync_reg;
    wd_arm_next = wd_arm_reg;
    wd_tmo_next = wd_tmo_reg;
    wd_fire = wd_arm_reg && !sel_pulse && (flags_sync_reg == zone_reg) && (wd_cnt_reg == WD_LAST);
    if (sel_pulse || flags_sync_reg != zone_reg) wd_cnt_next = '0;
    else if (wd_arm_reg) wd_cnt_next = wd_cnt_reg + 32'h1;
    else wd_cnt_next = wd_cnt_reg;
    if (wd_clear) begin
      wd_arm_next = 1'b0;
      wd_tmo_next = 1'b0;
    end
    if (sel_pulse) wd_arm_next = 1'b1;
    // Timeout beats a clear in the same cycle
    if (wd_fire) begin
      wd_tmo_next = 1'b1;
      wd_arm_next = 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dev_err_meta_reg <= 1'b0;
      dev_err_reg <= 1'b0;
      flags_meta_reg <= 3'h7;
      flags_sync_reg <= 3'h7;
      zone_reg <= 3'h7;
      wd_arm_reg <= 1'b0;
      wd_tmo_reg <= 1'b0;
      wd_cnt_reg <= '0;
    end else begin
      dev_err_meta_reg <= dev_err_pin;
      dev_err_reg <= dev_err_meta_reg;
      flags_meta_reg <= dev_flags_pin;
      flags_sync_reg <= flags_meta_reg;
      zone_reg <= zone_next;
      wd_arm_reg <= wd_arm_next;
      wd_tmo_reg <= wd_tmo_next;
      wd_cnt_reg <= wd_cnt_next;
    end
  end

  assign dw_addr = dw_addr_reg;
  assign dw_data = dw_data_reg;
  assign dw_wr = dw_wr_reg;
  assign cfg_go = go_reg;
  assign ent_ready = ready_reg;
  assign host_busy = busy_reg;
  assign err_code = err_reg;
  assign dev_error = dev_err_reg;
  assign wd_timeout = wd_tmo_reg;

  AST_COUNT_WORD: assert property (@(posedge clk_sys) disable iff (!rst_n)
    dw_wr_reg && dw_addr_reg == WORD_COUNT |-> dw_data_reg[15:8] == 8'h00
      && dw_data_reg[7:0] <= MAX_POS && $past(state_reg) == S_WCNT)
    else $error("count word malformed");
  AST_ENTRY_SPAN: assert property (@(posedge clk_sys) disable iff (!rst_n)
    dw_wr_reg && $past(state_reg) == S_WNUM |-> dw_addr_reg <= WORD_ENTRY_END - 10'h002
      && dw_addr_reg == entry_word($past(idx_reg)) && dw_data_reg[15:8] == 8'h00)
    else $error("entry number word misplaced");
  AST_DIST_WORDS: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_reg == S_WHI && phase_reg == PH_DIST
      |=> dw_wr_reg && dw_addr_reg == WORD_DIST_OUTER + {1'b0, $past(idx_reg), 1'b0}
      ##1 dw_wr_reg && dw_addr_reg == WORD_DIST_OUTER + {1'b0, $past(idx_reg, 2), 1'b1})
    else $error("distance words misplaced");
  AST_DIST_ORDER: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_reg == S_CHECK && count_reg <= MAX_POS && dist_reg.outer <= dist_reg.middle
      |=> state_reg == S_IDLE && err_reg == ERR_DIST && !dw_wr_reg)
    else $error("bad distance order not refused");
  AST_DIST_RANGE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_reg == S_CHECK && dist_reg.outer > DIST_MAX |=> err_reg != ERR_NONE)
    else $error("distance above limit not refused");
  AST_DUP_REFUSED: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_reg == S_WAIT_ENT && ent_valid && ready_reg && ent.num != NUM_SKIP
      && ent.num != 8'h00 && used_reg[ent.num] |=> err_reg == ERR_DUP [*2])
    else $error("duplicate number not refused");
  AST_VALUE_RANGE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_reg == S_WAIT_ENT && ent_valid && ready_reg && ent.num != NUM_SKIP
      && ent.num != 8'h00 && !used_reg[ent.num] && !rotary_reg && ent.value > LIN_LIMIT
      |=> err_reg == ERR_VALUE && state_reg == S_IDLE)
    else $error("out of range value not refused");
  AST_UPD_ADDR: assert property (@(posedge clk_sys) disable iff (!rst_n)
    state_reg == S_WHI && phase_reg == PH_UPD
      |=> dw_wr_reg && dw_addr_reg == entry_word($past(idx_reg) - 8'h01) + 10'h001)
    else $error("update not addressed by entry index");
  AST_WD_FIRE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wd_arm_reg && wd_cnt_reg == WD_LAST && !sel_pulse && flags_sync_reg == zone_reg
      |=> wd_timeout && !wd_arm_reg)
    else $error("zone watchdog did not fire");
endmodule // pos_table_host

// file: dev_model.sv
// Behavioural device: word store, duplicate check and range flags
`timescale 1ns/1ps
module dev_model (
  input wire logic clk_sys, // Clock
  input wire logic [9:0] dw_addr, // Word address
  input wire logic [15:0] dw_data, // Word data
  input wire logic dw_wr, // Write strobe
  input wire logic signed [31:0] act, // Actual value
  output logic dev_err_pin, // Duplicate number seen
  output logic [2:0] dev_flags_pin // Outer, middle, inner; 0 inside
);
  logic [15:0] mem [0:1023];
  logic [255:0] used = '0;
  logic signed [31:0] sp, d;
  initial dev_err_pin = 1'b0;
  initial foreach (mem[k]) mem[k] = 16'h0000;
  always @(posedge clk_sys) if (dw_wr) begin
    mem[dw_addr] <= dw_data;
    // count word opens a fresh table; later value writes just overwrite
    if (dw_addr == 10'h03a) begin
      used <= '0;
      dev_err_pin <= 1'b0;
    end
    if (dw_addr >= 10'h03c && (dw_addr - 10'h03c) % 3 == 0 && dw_data[7:0] != 8'hff) begin
      dev_err_pin <= dev_err_pin | used[dw_data[7:0]];
      used[dw_data[7:0]] <= 1'b1;
    end
  end
  // limits inclusive, first entry as setpoint
  // compared continuously; overrange forces every flag to 1
  always_comb begin
    sp = {mem[61], mem[62]};
    for (int j = 0; j < 3; j++) begin
      d = {mem[50 + 2 * j], mem[51 + 2 * j]};
      dev_flags_pin[2 - j] = !(act >= sp - d && act <= sp + d);
    end
    if (act > 32'sh0098967f || act < -32'sh0098967f) dev_flags_pin = 3'h7;
  end
endmodule // dev_model

// file: test_pos_table_host.sv
// Self-checking bench for the position-table host controller
`timescale 1ns/1ps
module test_pos_table_host;
  import pos_host_pkg::*;
  logic clk_sys = 1'b0, rst_n = 1'b0, cfg_start = 1'b0, cfg_bcd = 1'b0, cfg_rotary = 1'b0;
  logic ent_valid = 1'b0, upd_valid = 1'b0, sel_pulse = 1'b0, wd_clear = 1'b0;
  logic [7:0] cfg_count = 8'h00, upd_index = 8'h00;
  logic signed [31:0] cfg_rot_final = 32'sh00002710, upd_value = '0, act = '0;
  dist_set_type cfg_dist = '0;
  entry_type ent = '0;
  logic [9:0] dw_addr;
  logic [15:0] dw_data;
  logic dw_wr, cfg_go, ent_ready, host_busy, dev_error, wd_timeout, dev_err_pin;
  logic [2:0] err_code, dev_flags_pin;
  logic [25:0] wq [$];
  logic [25:0] exp_w [11] = '{{10'h032, 16'h0000}, {10'h033, 16'h0fa0}, {10'h034, 16'h0000},
    {10'h035, 16'h03e8}, {10'h036, 16'h0000}, {10'h037, 16'h01f4}, {10'h03a, 16'h0002},
    {10'h03c, 16'h0005}, {10'h03d, 16'h0000}, {10'h03e, 16'h2710}, {10'h03f, 16'h00ff}};
  int st [3] = '{499, 999, 3999};
  int failures = 0, comparisons = 0, gos = 0, i;
  always #25 clk_sys = ~clk_sys;
  pos_table_host #(.WD_CYCLES(20)) pos_table_host_i (.*);
  dev_model dev_model_i (.*);
  // Log every word write and completion pulse
  always @(posedge clk_sys) if (dw_wr) wq.push_back({dw_addr, dw_data});
  always @(posedge clk_sys) if (cfg_go) gos++;
  task chk(input logic [25:0] got, input logic [25:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task finish_test;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Bounded wait for the sequence to finish
  task wb;
    for (i = 0; i < 300 && host_busy; i++) @(posedge clk_sys) #1;
    if (i == 300) begin
      failures++;
      finish_test;
    end
    // One more edge so the logger sees the last word and the completion pulse
    @(posedge clk_sys) #1;
  endtask
  task cfg(input logic [7:0] n, input logic [31:0] o, m, k, input entry_type e0, e1);
    cfg_count = n;
    cfg_dist = {o, m, k};
    cfg_start = 1'b1;
    @(posedge clk_sys) #1 cfg_start = 1'b0;
    ent_valid = 1'b1;
    for (int j = 0; j < n; j++) begin
      ent = j ? e1 : e0;
      for (i = 0; i < 300 && !ent_ready && host_busy; i++) @(posedge clk_sys) #1;
      if (i == 300) begin
        failures++;
        finish_test;
      end
      if (ent_ready) @(posedge clk_sys) #1;
    end
    ent_valid = 1'b0;
    wb;
  endtask
  task upd(input logic [7:0] k, input logic [31:0] v);
    upd_index = k;
    upd_value = v;
    upd_valid = 1'b1;
    @(posedge clk_sys) #1 upd_valid = 1'b0;
    @(posedge clk_sys) #1;
    wb;
  endtask
  task pulse_sel;
    sel_pulse = 1'b1;
    @(posedge clk_sys) #1 sel_pulse = 1'b0;
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    cfg(8'hff, 400, 100, 50, '0, '0);
    chk(26'(err_code), 2);
    cfg(1, 100, 400, 50, '0, '0);
    chk(26'(err_code), 1);
    cfg(2, 400, 100, 50, {8'h05, 32'h0}, {8'h05, 32'h0});
    chk(26'(err_code), 4);
    wq = {};
    cfg(2, 4000, 1000, 500, {8'h05, 32'h2710}, {8'hff, 32'h7});
    chk(26'(wq.size()), 11);
    for (int j = 0; j < 11; j++) chk(wq[j], exp_w[j]);
    chk(26'(gos), 1);
    wq = {};
    upd(1, -2);
    chk(wq[0], {10'h03d, 16'hffff});
    chk(wq[1], {10'h03e, 16'hfffe});
    upd(3, 0);
    chk(26'(err_code), 6);
    act = 32'sd10000;
    pulse_sel;
    repeat (30) @(posedge clk_sys);
    #1 chk(26'(wd_timeout), 1);
    wd_clear = 1'b1;
    @(posedge clk_sys) #1 wd_clear = 1'b0;
    @(posedge clk_sys) #1 chk(26'(wd_timeout), 0);
    // Each zone left well inside the limit, so no timeout
    pulse_sel;
    foreach (st[k]) begin
      repeat (10) @(posedge clk_sys);
      #1 act = st[k];
    end
    repeat (10) @(posedge clk_sys);
    #1 chk(26'(wd_timeout), 0);
    // Signed BCD transfer: sign nibble in the first value word, digits in both words
    cfg_bcd = 1'b1;
    wq = {};
    cfg(1, 4000, 1000, 500, {8'h07, 32'hffed2979}, '0);
    chk(26'(wq.size()), 10);
    chk(wq[1], {10'h033, 16'h4000});
    chk(wq[8], {10'h03d, 16'hf123});
    chk(wq[9], {10'h03e, 16'h4567});
    chk(26'(gos), 2);
    chk(26'(dev_error), 0);
    finish_test;
  end
endmodule // test_pos_table_host
